//--- rtl/qrb_ctrl_end.sv
`timescale 1ns/100ps
// Memory controller end: issues reads and buffered writes over the link.
// Assumes user logic on core_clk; write bursts queue in a FIFO.
module qrb_ctrl_end #(
  parameter int DATA_W     = qrb_pkg::DATA_W_DEF,
  parameter int ADDR_W     = qrb_pkg::ADDR_W_DEF,
  parameter int FIFO_DEPTH = qrb_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic                                                  core_clk,
  input  wire logic                                                  rst,
  input  wire logic                                                  rdReqValid,
  output logic                                                       rdReqReady,
  input  wire logic [ADDR_W-1:0]                                     rdReqAddr,
  output logic                                                       rdRespValid,
  output logic      [DATA_W-1:0]                                     rdRespData,
  input  wire logic                                                  wrReqValid,
  output logic                                                       wrReqReady,
  input  wire logic [ADDR_W-1:0]                                     wrReqAddr,
  input  wire logic [qrb_pkg::BURST_LEN*DATA_W-1:0]                  wrReqData,
  input  wire logic [qrb_pkg::BURST_LEN*qrb_pkg::qrb_lanes(DATA_W)-1:0] wrReqSel_n,
  qrb_link_if.ctl                                                    link
);
  localparam int LANES  = qrb_pkg::qrb_lanes(DATA_W);
  localparam int BL     = qrb_pkg::BURST_LEN;
  localparam int BURST_W = BL * (DATA_W + LANES);
  localparam logic [1:0] LAST_IDX = 2'(BL - 1);

  qrb_pkg::qrb_op_t      lastOp;
  logic                  kNext;
  logic                  doRd;
  logic                  doWr;
  logic                  rdHeld;
  logic                  next_rdHeld;
  logic [ADDR_W-1:0]     rdHeldAddr;
  logic                  fifoValid;
  logic [ADDR_W+BURST_W-1:0] fifoData;
  logic                  wrPend;
  logic [BURST_W-1:0]    wrPendBurst;
  logic                  wrAct;
  logic [BURST_W-1:0]    wrOutBurst;
  logic [1:0]            wrIdx;
  logic                  wrStart;
  logic [1:0]            wrIdxSel;
  logic [BURST_W-1:0]    wrBurst;

  qrb_fifo #(
    .WIDTH (ADDR_W + BURST_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inValid  (wrReqValid),
    .inReady  (wrReqReady),
    .inData   ({wrReqAddr, wrReqSel_n, wrReqData}),
    .outValid (fifoValid),
    .outReady (doWr),
    .outData  (fifoData)
  );

  // Requests go out only in beats that begin a K rise
  assign kNext       = !link.kPos;
  assign doRd        = kNext && rdHeld && lastOp != qrb_pkg::OP_READ;
  assign doWr        = kNext && fifoValid && lastOp != qrb_pkg::OP_WRITE && !doRd;
  assign next_rdHeld = doRd ? 1'b0 : (rdHeld || (rdReqValid && rdReqReady));

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      link.kPos              <= qrb_pkg::K_RESET;
      link.readPortSelect_n  <= qrb_pkg::SEL_IDLE_N;
      link.writePortSelect_n <= qrb_pkg::SEL_IDLE_N;
      link.addr              <= '0;
      lastOp                 <= qrb_pkg::OP_IDLE;
      rdHeld                 <= 1'b0;
      rdHeldAddr             <= '0;
      rdReqReady             <= 1'b0;
      rdRespValid            <= 1'b0;
      rdRespData             <= '0;
    end
    else
    begin
      link.kPos              <= kNext;
      link.readPortSelect_n  <= !doRd;
      link.writePortSelect_n <= !doWr;
      if (doRd)
        link.addr <= rdHeldAddr;
      else if (doWr)
        link.addr <= fifoData[ADDR_W+BURST_W-1 -: ADDR_W];
      if (kNext)
        lastOp <= doRd ? qrb_pkg::OP_READ : (doWr ? qrb_pkg::OP_WRITE : qrb_pkg::OP_IDLE);
      rdHeld     <= next_rdHeld;
      rdReqReady <= !next_rdHeld;
      if (rdReqValid && rdReqReady)
        rdHeldAddr <= rdReqAddr;
      rdRespValid <= !link.rdOe_n;
      rdRespData  <= link.rdData;
    end

  // Write words follow at the next K rise, one per beat
  assign wrStart  = kNext && wrPend && !wrAct;
  assign wrIdxSel = wrStart ? 2'h0 : wrIdx;
  assign wrBurst  = wrStart ? wrPendBurst : wrOutBurst;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      wrPend                 <= 1'b0;
      wrPendBurst            <= '0;
      wrAct                  <= 1'b0;
      wrOutBurst             <= '0;
      wrIdx                  <= 2'h0;
      link.wrData            <= '0;
      link.byteWriteSelect_n <= '1;
    end
    else
    begin
      if (doWr)
      begin
        wrPend      <= 1'b1;
        wrPendBurst <= fifoData[BURST_W-1:0];
      end
      else if (wrStart)
        wrPend <= 1'b0;
      if (wrStart || wrAct)
      begin
        link.wrData            <= wrBurst[wrIdxSel*DATA_W +: DATA_W];
        link.byteWriteSelect_n <= wrBurst[BL*DATA_W + wrIdxSel*LANES +: LANES];
        wrIdx                  <= wrIdxSel + 2'h1;
        if (wrStart)
        begin
          wrAct      <= 1'b1;
          wrOutBurst <= wrPendBurst;
        end
        else if (wrIdx == LAST_IDX)
          wrAct <= 1'b0;
      end
      else
      begin
        link.wrData            <= '0;
        link.byteWriteSelect_n <= '1;
      end
    end
endmodule

//--- rtl/qrb_device_end.sv
`timescale 1ns/100ps
// SRAM device end: read and write port sequencing and the four storage banks.
// Assumes the link is driven from core_clk; kPos high marks a K rise beat.
module qrb_device_end #(
  parameter int DATA_W     = qrb_pkg::DATA_W_DEF,
  parameter int ADDR_W     = qrb_pkg::ADDR_W_DEF,
  parameter int BANK_DEPTH = qrb_pkg::BANK_DEPTH_DEF
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pllDisable_n,
  qrb_link_if.dev   link
);
  localparam int LANES  = qrb_pkg::qrb_lanes(DATA_W);
  localparam int LANE_W = DATA_W / LANES;
  localparam int BL     = qrb_pkg::BURST_LEN;
  localparam logic [1:0] LAST_IDX = 2'(BL - 1);
  localparam logic [2:0] WAIT_ON  = 3'(qrb_pkg::RD_LAT_BEATS_ON - 1);
  localparam logic [2:0] WAIT_OFF = 3'(qrb_pkg::RD_LAT_BEATS_OFF - 1);

  logic                pllSync1;
  logic                pllOn;
  qrb_pkg::qrb_op_t    lastOp;
  logic                kEdge;
  logic                acceptRd;
  logic                acceptWr;

  logic                rdPend;
  logic [2:0]          rdWait;
  logic [ADDR_W-1:0]   rdPendAddr;
  logic                rdAct;
  logic [ADDR_W-1:0]   rdActAddr;
  logic [1:0]          rdIdx;
  logic                rdStart;
  logic [ADDR_W-1:0]   rdWordAddr;
  logic [1:0]          rdWordIdx;
  logic [DATA_W-1:0]   rdWord;
  logic                rdFwdHit;

  logic                wrPend;
  logic [ADDR_W-1:0]   wrPendAddr;
  logic                wrAct;
  logic [ADDR_W-1:0]   wrAddr;
  logic [1:0]          wrIdx;
  logic                wrStart;
  logic                wrTake;
  logic [1:0]          wrTakeIdx;
  logic                wrFull;
  logic [BL-1:0]       wrHave;
  logic [DATA_W-1:0]   wrBuf [BL];
  logic [LANES-1:0]    wrSel_n [BL];
  logic [DATA_W-1:0]   bankQ [BL];

  // Replace selected lanes of a stored word with fresh data
  function automatic logic [DATA_W-1:0] fwdMerge(
    input logic [DATA_W-1:0] stored,
    input logic [DATA_W-1:0] fresh,
    input logic [LANES-1:0]  sel_n,
    input logic              hit
  );
    logic [DATA_W-1:0] word;
    word = stored;
    for (int l = 0; l < LANES; l++)
      if (hit && !sel_n[l])
        word[l*LANE_W +: LANE_W] = fresh[l*LANE_W +: LANE_W];
    return word;
  endfunction

  // Strap pin crosses in through two flops
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pllSync1 <= qrb_pkg::PLL_RESET;
      pllOn    <= qrb_pkg::PLL_RESET;
    end
    else
    begin
      pllSync1 <= pllDisable_n;
      pllOn    <= pllSync1;
    end

  assign kEdge = link.kPos;
  // Read beats write unless a read was taken on the previous K rise
  assign acceptRd = kEdge && !link.readPortSelect_n && lastOp != qrb_pkg::OP_READ;
  assign acceptWr = kEdge && !link.writePortSelect_n && lastOp != qrb_pkg::OP_WRITE
                    && !acceptRd;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      lastOp <= qrb_pkg::OP_IDLE;
    else if (kEdge)
      lastOp <= acceptRd ? qrb_pkg::OP_READ : (acceptWr ? qrb_pkg::OP_WRITE : qrb_pkg::OP_IDLE);

  // Read latency countdown from request to first word
  assign rdStart = rdPend && rdWait == 3'h0;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      rdPend     <= 1'b0;
      rdWait     <= 3'h0;
      rdPendAddr <= '0;
    end
    else if (acceptRd)
    begin
      rdPend     <= 1'b1;
      rdWait     <= pllOn ? WAIT_ON : WAIT_OFF;
      rdPendAddr <= link.addr;
    end
    else if (rdStart)
      rdPend <= 1'b0;
    else if (rdPend)
      rdWait <= rdWait - 3'h1;

  assign rdWordAddr = rdStart ? rdPendAddr : rdActAddr;
  assign rdWordIdx  = rdStart ? 2'h0 : rdIdx;
  assign rdFwdHit   = wrHave[rdWordIdx] && wrAddr == rdWordAddr;
  assign rdWord     = fwdMerge(bankQ[rdWordIdx], wrBuf[rdWordIdx], wrSel_n[rdWordIdx], rdFwdHit);

  // Output one word per beat, lowest word first
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      rdAct       <= 1'b0;
      rdActAddr   <= '0;
      rdIdx       <= 2'h0;
      link.rdData <= '0;
      link.rdOe_n <= qrb_pkg::OE_IDLE_N;
    end
    else if (rdStart || rdAct)
    begin
      link.rdData <= rdWord;
      link.rdOe_n <= 1'b0;
      rdIdx       <= rdWordIdx + 2'h1;
      if (rdStart)
      begin
        rdAct     <= 1'b1;
        rdActAddr <= rdPendAddr;
      end
      else if (rdIdx == LAST_IDX)
        rdAct <= 1'b0;
    end
    else
    begin
      link.rdData <= '0;
      link.rdOe_n <= qrb_pkg::OE_IDLE_N;
    end

  // Write words begin at the K rise after the request
  assign wrStart   = kEdge && wrPend && !wrAct;
  assign wrTake    = wrStart || wrAct;
  assign wrTakeIdx = wrStart ? 2'h0 : wrIdx;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      wrPend     <= 1'b0;
      wrPendAddr <= '0;
      wrAct      <= 1'b0;
      wrAddr     <= '0;
      wrIdx      <= 2'h0;
      wrFull     <= 1'b0;
      wrHave     <= '0;
    end
    else
    begin
      wrFull <= wrAct && wrIdx == LAST_IDX;
      if (acceptWr)
      begin
        wrPend     <= 1'b1;
        wrPendAddr <= link.addr;
      end
      else if (wrStart)
        wrPend <= 1'b0;
      if (wrStart)
      begin
        wrAct  <= 1'b1;
        wrAddr <= wrPendAddr;
        wrIdx  <= 2'h1;
        wrHave <= BL'(1);
      end
      else
      begin
        if (wrAct)
        begin
          wrIdx  <= wrIdx + 2'h1;
          wrHave <= wrHave | (BL'(1) << wrIdx);
          if (wrIdx == LAST_IDX)
            wrAct <= 1'b0;
        end
        else if (wrFull)
          wrHave <= '0;
      end
    end

  // Word and byte selects held until the burst is committed
  always_ff @(posedge core_clk)
    if (wrTake)
    begin
      wrBuf[wrTakeIdx]   <= link.wrData;
      wrSel_n[wrTakeIdx] <= link.byteWriteSelect_n;
    end

  // Four banks, word n of a burst lives in bank n
  for (genvar b = 0; b < BL; b++)
  begin : g_bank
    logic [DATA_W-1:0] mem [BANK_DEPTH];

    always_ff @(posedge core_clk)
      if (wrFull)
        mem[wrAddr] <= fwdMerge(mem[wrAddr], wrBuf[b], wrSel_n[b], 1'b1);

    assign bankQ[b] = mem[rdWordAddr];
  end

  // Word width must be one of the supported configurations
  if (DATA_W != 8 && DATA_W != 9 && DATA_W != 18 && DATA_W != 36)
  begin : g_bad_width
    $error("unsupported word width");
  end
endmodule

//--- rtl/qrb_fifo.sv
`timescale 1ns/100ps
// Synchronous FIFO with valid and ready on both sides.
// Assumes a single clock; outData is valid while outValid is high.
module qrb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = qrb_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             push;
  logic             pop;

  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;
  assign outData = store[rdPtr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + CNT_W'(1);
    else if (pop && !push)
      next_count = count - CNT_W'(1);
  end

  always_ff @(posedge core_clk)
    if (push)
      store[wrPtr] <= inData;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      count    <= '0;
      inReady  <= 1'b0;
      outValid <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + PTR_W'(1);
      if (pop)
        rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + PTR_W'(1);
      count    <= next_count;
      inReady  <= next_count != FULL;
      outValid <= next_count != '0;
    end
endmodule

//--- shared/qrb_link_if.sv
`timescale 1ns/100ps
// Link between memory controller and SRAM device ends.
// Assumes both ends run on the same core_clk; K bar is the inverse of kPos.
interface qrb_link_if #(
  parameter int DATA_W = qrb_pkg::DATA_W_DEF,
  parameter int ADDR_W = qrb_pkg::ADDR_W_DEF,
  parameter int LANES  = qrb_pkg::qrb_lanes(DATA_W)
);
  logic              kPos;
  logic              readPortSelect_n;
  logic              writePortSelect_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData;
  logic [LANES-1:0]  byteWriteSelect_n;
  logic [DATA_W-1:0] rdData;
  logic              rdOe_n;

  modport dev (
    input  kPos,
    input  readPortSelect_n,
    input  writePortSelect_n,
    input  addr,
    input  wrData,
    input  byteWriteSelect_n,
    output rdData,
    output rdOe_n
  );

  modport ctl (
    output kPos,
    output readPortSelect_n,
    output writePortSelect_n,
    output addr,
    output wrData,
    output byteWriteSelect_n,
    input  rdData,
    input  rdOe_n
  );
endinterface

//--- shared/qrb_pkg.sv
// Constants and types shared by both ends of the burst SRAM link.
// Assumes one core clock; each core_clk cycle is one half period of K.
// Functional notes
// - PLL enabled: read data two cycles later
// - PLL disabled: read data one cycle later
// - Accesses start only on K rises
// - All data and control registered per beat
// - Every access is four words, two cycles
// - Word width parameter: 8, 9, 18, 36
// - Storage split into four banks
// - Read select low captures read address
// - Lowest word first, one word per beat
// - Read right after accepted read ignored
// - Deselected read finishes, then outputs float
// - Write select low captures write address
// - Write words start next K rise
// - Collect four words, then commit burst
// - Write right after accepted write ignored
// - Deselected write ignores further inputs
// - Byte selects sampled with each word
// - Unselected bytes keep stored contents
// - Read returns newest, forwarded write data
// - Both selected: alternate, read first
// - Port selects sampled on K only
package qrb_pkg;
  localparam int DATA_W_DEF         = 18;
  localparam int ADDR_W_DEF         = 19;
  localparam int BURST_LEN          = 4;
  localparam int BANK_DEPTH_DEF     = 524288;
  localparam int BEATS_PER_CYC      = 2;
  localparam int RD_LAT_CYC_PLL_ON  = 2;
  localparam int RD_LAT_CYC_PLL_OFF = 1;
  localparam int RD_LAT_BEATS_ON    = RD_LAT_CYC_PLL_ON * BEATS_PER_CYC;
  localparam int RD_LAT_BEATS_OFF   = RD_LAT_CYC_PLL_OFF * BEATS_PER_CYC;
  localparam int FIFO_DEPTH_DEF     = 16;
  localparam logic SEL_IDLE_N       = 1'b1;
  localparam logic OE_IDLE_N        = 1'b1;
  localparam logic K_RESET          = 1'b0;
  localparam logic PLL_RESET        = 1'b1;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } qrb_op_t;

  // Byte or nibble lanes per word
  function automatic int qrb_lanes(input int w);
    if (w == 8)
      return 2;
    else if (w == 9)
      return 1;
    else if (w == 36)
      return 4;
    else
      return 2;
  endfunction
endpackage

//--- test/qrb_link_assertions.sv
`timescale 1ns/100ps
// Checker for the link between controller and device ends.
// Assumes the watched device end runs with its PLL enabled.
module qrb_link_chk #(
  parameter int DATA_W = qrb_pkg::DATA_W_DEF,
  parameter int ADDR_W = qrb_pkg::ADDR_W_DEF,
  parameter int LANES  = qrb_pkg::qrb_lanes(DATA_W)
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              kPos,
  input wire logic              readPortSelect_n,
  input wire logic              writePortSelect_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [LANES-1:0]  byteWriteSelect_n,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic              rdOe_n
);
  logic wrReqSeen;

  // Write request taken in this K beat
  assign wrReqSeen = kPos && !writePortSelect_n;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence rdTake;
    kPos && !readPortSelect_n;
  endsequence
  sequence wrTake;
    kPos && !writePortSelect_n;
  endsequence
  sequence rdBurst;
    !rdOe_n [*4];
  endsequence

  chk_kpos_toggle: assert property (!$past(rst) |-> kPos != $past(kPos))
    else $error("K level did not toggle");
  chk_rsel_kbeat: assert property (!readPortSelect_n |-> kPos)
    else $error("read select outside K beat");
  chk_wsel_kbeat: assert property (!writePortSelect_n |-> kPos)
    else $error("write select outside K beat");
  chk_rd_spacing: assert property (rdTake |-> ##2 readPortSelect_n)
    else $error("read issued on next K rise");
  chk_wr_spacing: assert property (wrTake |-> ##2 writePortSelect_n)
    else $error("write issued on next K rise");
  chk_rd_latency: assert property (rdTake |-> ##5 rdBurst)
    else $error("read words not driven two cycles later");
  chk_rd_cause: assert property ($fell(rdOe_n) |-> !$past(readPortSelect_n, 5) && $past(kPos, 5))
    else $error("read output enabled without request");
  chk_rd_float: assert property (rdOe_n |-> rdData == '0)
    else $error("read data not idle while released");
  chk_rd_release: assert property (rdTake ##4 readPortSelect_n |-> ##5 rdOe_n)
    else $error("read output not released after burst");
  chk_addr_hold: assert property ((readPortSelect_n && writePortSelect_n) |-> $stable(addr))
    else $error("address moved without a select");
  chk_wr_words: assert property ((wrData != '0 || byteWriteSelect_n != '1) |->
    $past(wrReqSeen, 2) || $past(wrReqSeen, 3) || $past(wrReqSeen, 4) || $past(wrReqSeen, 5))
    else $error("write word driven outside a burst");
endmodule

//--- test/tb.sv
`timescale 1ns/100ps
// Testbench: controller and device ends over one link, plus a
// second device end (PLL off) driven directly. Assumes qrb_pkg compiled.
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  localparam int DW = 18;
  localparam int AW = 4;
  logic              core_clk, rst, rdT, wrT, sawFull;
  logic              rdReqValid, rdReqReady, rdRespValid, wrReqValid, wrReqReady;
  logic [AW-1:0]     rdReqAddr, wrReqAddr;
  logic [DW-1:0]     rdRespData;
  logic [4*DW-1:0]   wrReqData;
  logic [7:0]        wrReqSel_n;
  int                fails = 0;
  int                checks = 0;
  logic [DW-1:0]     mem [16][4];
  logic [DW-1:0]     expQ [$];
  logic [DW-1:0]     wa [4];
  logic [DW-1:0]     wb [4];
  logic [AW-1:0]     wqA [$];
  logic [AW-1:0]     rq [$];
  logic [4*DW-1:0]   wqD [$];
  logic [7:0]        wqS [$];
  qrb_pkg::qrb_op_t  lastOp;
  logic [DW-1:0]     expW;
  logic [AW-1:0]     expA;

  qrb_link_if #(.DATA_W(DW), .ADDR_W(AW)) link ();
  qrb_link_if #(.DATA_W(DW), .ADDR_W(AW)) link2 ();
  qrb_ctrl_end #(.DATA_W(DW), .ADDR_W(AW)) qrb_ctrl_end_inst (.core_clk(core_clk), .rst(rst),
    .rdReqValid(rdReqValid), .rdReqReady(rdReqReady), .rdReqAddr(rdReqAddr), .rdRespValid(rdRespValid),
    .rdRespData(rdRespData), .wrReqValid(wrReqValid), .wrReqReady(wrReqReady), .wrReqAddr(wrReqAddr),
    .wrReqData(wrReqData), .wrReqSel_n(wrReqSel_n), .link(link));
  qrb_device_end #(.DATA_W(DW), .ADDR_W(AW), .BANK_DEPTH(16)) qrb_device_end_inst (.core_clk(core_clk),
    .rst(rst), .pllDisable_n(1'b1), .link(link));
  qrb_device_end #(.DATA_W(DW), .ADDR_W(AW), .BANK_DEPTH(16)) qrb_device_end_inst2 (.core_clk(core_clk),
    .rst(rst), .pllDisable_n(1'b0), .link(link2));
  qrb_link_chk #(.DATA_W(DW), .ADDR_W(AW), .LANES(2)) qrb_link_chk_inst (.core_clk(core_clk), .rst(rst),
    .kPos(link.kPos), .readPortSelect_n(link.readPortSelect_n), .writePortSelect_n(link.writePortSelect_n),
    .addr(link.addr), .wrData(link.wrData), .byteWriteSelect_n(link.byteWriteSelect_n),
    .rdData(link.rdData), .rdOe_n(link.rdOe_n));

  initial
  begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) link2.kPos <= rst ? 1'b0 : ~link2.kPos;

  // Reference model: user queues, link-level take, response compare
  always @(posedge core_clk)
  begin
    if (wrReqValid && wrReqReady)
    begin
      wqA.push_back(wrReqAddr);
      wqD.push_back(wrReqData);
      wqS.push_back(wrReqSel_n);
    end
    if (!wrReqReady)
      sawFull = 1;
    if (rdReqValid && rdReqReady)
      rq.push_back(rdReqAddr);
    if (rdRespValid)
    begin
      expW = (expQ.size() > 0) ? expQ.pop_front() : {DW{1'bx}};
      `CHK(rdRespData, expW)
    end
    if (rst)
      lastOp = qrb_pkg::OP_IDLE;
    else if (link.kPos)
    begin
      rdT = !link.readPortSelect_n && lastOp != qrb_pkg::OP_READ;
      wrT = !link.writePortSelect_n && lastOp != qrb_pkg::OP_WRITE && !rdT;
      if (rdT)
      begin
        expA = rq.pop_front();
        `CHK(link.addr, expA)
        for (int n = 0; n < 4; n++) expQ.push_back(mem[link.addr][n]);
      end
      if (wrT)
      begin
        expA = wqA.pop_front();
        `CHK(link.addr, expA)
        for (int n = 0; n < 8; n++)
          if (!wqS[0][n]) mem[link.addr][n/2][(n%2)*9 +: 9] = wqD[0][n*9 +: 9];
        void'(wqD.pop_front());
        void'(wqS.pop_front());
      end
      lastOp = rdT ? qrb_pkg::OP_READ : wrT ? qrb_pkg::OP_WRITE : qrb_pkg::OP_IDLE;
    end
  end

  task automatic summarize;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic req(input logic isRd, input logic [AW-1:0] a, input logic [7:0] s);
    int k;
    rdReqValid = isRd;
    wrReqValid = !isRd;
    rdReqAddr = a;
    wrReqAddr = a;
    wrReqData = 72'({$urandom(), $urandom(), $urandom()});
    wrReqSel_n = s;
    for (k = 0; k < 300; k++)
    begin
      @(posedge core_clk);
      if (isRd ? rdReqReady : wrReqReady)
        break;
    end
    if (k == 300)
    begin
      fails++;
      summarize();
    end
    #1;
  endtask

  task automatic waitEmpty;
    int k;
    rdReqValid = 0;
    wrReqValid = 0;
    for (k = 0; k < 600; k++)
    begin
      if (wqA.size() == 0 && rq.size() == 0 && expQ.size() == 0)
        break;
      @(posedge core_clk);
    end
    if (k == 600)
    begin
      fails++;
      summarize();
    end
    #1;
  endtask

  task automatic d2(input logic r, w, input logic [DW-1:0] d, input logic [1:0] s);
    link2.readPortSelect_n = r;
    link2.writePortSelect_n = w;
    link2.addr = r && w ? AW'($urandom) : 4'h3;
    link2.wrData = d;
    link2.byteWriteSelect_n = s;
    @(posedge core_clk);
    #1;
  endtask

  initial
  begin
    int k;
    int a;
    rst = 1;
    {rdReqValid, wrReqValid, rdReqAddr, wrReqAddr, wrReqData, wrReqSel_n} = '0;
    {link2.kPos, link2.addr, link2.wrData} = '0;
    {link2.readPortSelect_n, link2.writePortSelect_n, link2.byteWriteSelect_n} = '1;
    void'($urandom(22));
    repeat (20) @(posedge core_clk);
    #1 rst = 0;
    req(0, 4'h0, 8'h00);
    sawFull = 0;
    // Full-lane fill, 24 writes pushed, more than the buffer holds, so it must refuse
    for (k = 1; k < 24; k++) req(0, AW'(k), 8'h00);
    `CHK(sawFull, 1'b1)
    waitEmpty();
    // Mixed traffic, each write followed by a read, often to the same place
    for (k = 0; k < 30; k++)
    begin
      a = $urandom_range(15, 0);
      req(0, AW'(a), 8'($urandom));
      req(1, ($urandom_range(1, 0) == 1) ? AW'(a) : AW'($urandom), 8'hFF);
      if (k % 3 == 0)
        req(1, AW'($urandom), 8'hFF);
    end
    waitEmpty();
    // Second device end: PLL off, partial write, refused back-to-back read
    if (link2.kPos !== 1'b1)
      d2(1, 1, DW'($urandom), 2'($urandom));
    for (k = 0; k < 4; k++)
    begin
      wa[k] = DW'($urandom);
      wb[k] = DW'($urandom);
    end
    d2(1, 0, DW'($urandom), 2'($urandom));
    d2(1, 1, DW'($urandom), 2'($urandom));
    for (k = 0; k < 4; k++) d2(1, k != 0, wa[k], 2'b00);
    d2(1, 0, DW'($urandom), 2'($urandom));
    d2(1, 1, DW'($urandom), 2'($urandom));
    for (k = 0; k < 4; k++) d2(1, 1, wb[k], 2'(k));
    d2(0, 0, DW'($urandom), 2'($urandom));
    d2(1, 1, DW'($urandom), 2'($urandom));
    d2(0, 1, DW'($urandom), 2'($urandom));
    for (k = 0; k < 4; k++)
    begin
      `CHK(link2.rdOe_n, 1'b0)
      `CHK(link2.rdData, {k[1] ? wa[k][17:9] : wb[k][17:9], k[0] ? wa[k][8:0] : wb[k][8:0]})
      d2(1, 1, DW'($urandom), 2'($urandom));
    end
    `CHK(link2.rdOe_n, 1'b1)
    `CHK(link2.rdData, 18'h00000)
    summarize();
  end
endmodule
